// >>> tcmc_map.vh
// Register map, field positions and reset values of the channel mode configuration block
`ifndef TCMC_MAP_VH
`define TCMC_MAP_VH
`define TCMC_ADDR_W 3
`define TCMC_OFS_MODE1 3'h0
`define TCMC_OFS_MODE2 3'h1
`define TCMC_OFS_CTRL 3'h2
`define TCMC_OFS_STAT 3'h3
`define TCMC_OFS_CAPCNT 3'h4
`define TCMC_MODE_RST 16'h0000
`define TCMC_CTRL_RST 16'h0000
`define TCMC_CTRL_MASK 16'h3333
`define TCMC_DIR_OUT 2'h0
`define TCMC_DIR_OWN 2'h1
`define TCMC_DIR_PAIR 2'h2
`define TCMC_DIR_TRG 2'h3
`define TCMC_DIR_LSB 0
`define TCMC_DIV_LSB 2
`define TCMC_FLT_LSB 4
`define TCMC_OSEN_BIT 7
`define TCMC_OCTRL_LSB 4
`define TCMC_OBEN_BIT 3
`define TCMC_OIEN_BIT 2
`define TCMC_HI_LSB 8
`define TCMC_EN_BIT 0
`define TCMC_POL_BIT 1
`define TCMC_SLAVE_TRIGGER_SELECT_INT 1'h1
`endif

// >>> tcmc_filter.v
// Digital edge filter for one capture input
`timescale 1ns/1ps
module tcmc_filter
(
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Control
  input wire [3:0] cfg,
  input wire dts_tick,
  input wire [3:0] dts_cnt,
  // Data
  input wire din,
  output reg dout_q
);
  reg [3:0] run_q;
  reg [3:0] need;
  reg every_clk;
  reg [3:0] div;
  wire tick;

  // Sampling divisor and consecutive count per filter code
  always @*
  begin
    every_clk = 1'b0;
    div = 4'h1;
    need = 4'h1;
    case (cfg)
      4'h0: begin div = 4'h1; need = 4'h1; end
      4'h1: begin every_clk = 1'b1; need = 4'h2; end
      4'h2: begin every_clk = 1'b1; need = 4'h4; end
      4'h3: begin every_clk = 1'b1; need = 4'h8; end
      4'h4: begin div = 4'h2; need = 4'h6; end
      4'h5: begin div = 4'h2; need = 4'h8; end
      4'h6: begin div = 4'h4; need = 4'h6; end
      4'h7: begin div = 4'h4; need = 4'h8; end
      4'h8: begin div = 4'h8; need = 4'h6; end
      4'h9: begin div = 4'h8; need = 4'h8; end
      4'hA: begin div = 4'hF; need = 4'h5; end
      4'hB: begin div = 4'hF; need = 4'h6; end
      4'hC: begin div = 4'hF; need = 4'h8; end
      4'hD: begin div = 4'hF; need = 4'h5; end
      4'hE: begin div = 4'hF; need = 4'h6; end
      default: begin div = 4'hF; need = 4'h8; end
    endcase
  end

  // Divide 16 is approximated by the 16-step base counter wrapping
  assign tick = every_clk | (dts_tick & ((div == 4'hF) ? (dts_cnt == 4'h0) : ((dts_cnt & (div - 4'h1)) == 4'h0)));

  always @(posedge MCLK)
  begin
    if (RST)
    begin
      run_q <= 4'h0;
      dout_q <= 1'b0;
    end
    else if (tick)
    begin
      if (din == dout_q)
        run_q <= 4'h0;
      else if (run_q + 4'h1 >= need)
      begin
        dout_q <= din; // R07
        run_q <= 4'h0;
      end
      else
        run_q <= run_q + 4'h1;
    end
  end
endmodule // tcmc_filter

// >>> tcmc_divider.v
// Capture prescaler for one channel
`timescale 1ns/1ps
module tcmc_divider
(
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Control
  input wire enable,
  input wire [1:0] sel,
  // Events
  input wire edge_in,
  output wire capture
);
  reg [2:0] cnt_q;
  wire [2:0] mask = (sel == 2'h0) ? 3'h0 : (sel == 2'h1) ? 3'h1 : (sel == 2'h2) ? 3'h3 : 3'h7;

  assign capture = enable & edge_in & ((cnt_q & mask) == mask); // R10

  always @(posedge MCLK)
  begin
    if (RST || !enable)
      cnt_q <= 3'h0; // R11
    else if (edge_in)
      cnt_q <= cnt_q + 3'h1;
  end
endmodule // tcmc_divider

// >>> tcmc_top.v
// Channel mode configuration of a four-channel capture/compare timer
// Function
// R01: Channel 2 direction: output, own, ch1, trigger
// R02: Channel 1 direction: output, own, ch2, trigger
// R03: Channel 3 direction: output, own, ch4, trigger
// R04: Channel 4 direction: output, own, ch3, trigger
// R05: Trigger source needs internal slave trigger selection
// R06: Direction written only while channel disabled
// R07: Edge passes after N consecutive equal samples
// R08: Filter codes set sampling rate and N
// R09: Channel 1 filter bits 7:4, divider 3:2
// R10: Divider captures every 1, 2, 4, 8 edges
// R11: Divider counter cleared while channel disabled
// R12: Channel 4 filter 15:12, divider 11:10, direction 9:8
// R13: Channel 3 filter 7:4, divider 3:2, direction 1:0
// R14: Channel 4 output fields in bits 15:10
// R15: Channel 3 output fields in bits 7:2
// R16: Bit meaning follows owning channel direction
// R17: Polarity picks capture edge, inverts trigger
// R18: Enable bit gates channel input or output
// R19: Mode fields reset to zero
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tcmc_map.vh"
module tcmc_top
(
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Register port
  input wire [`TCMC_ADDR_W-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // Capture inputs and trigger
  input wire [3:0] CH_IN,
  input wire TRIG_IN,
  input wire SLAVE_TRIGGER_SELECT,
  // Capture events and filtered trigger views
  output reg [3:0] CAPTURE,
  output reg [3:0] CH_TRIG,
  // Output-mode fields, valid when a channel is an output
  output reg [3:0] OUT_SWITCH_EN,
  output reg [11:0] OUT_CONTROL,
  output reg [3:0] OUT_BUFFER_EN,
  output reg [3:0] OUT_IMMEDIATE_EN,
  output reg [3:0] OUT_ENABLE
);
  reg [15:0] mode1_q;
  reg [15:0] mode2_q;
  reg [15:0] ctrl_q;
  reg [3:0] sel_lvl_q;
  reg [15:0] capcnt_q;
  reg [3:0] dts_cnt_q;
  wire [3:0] filt;
  wire [3:0] cap;
  reg [3:0] chan_in;
  reg [3:0] edge_ev;
  wire [7:0] mb [0:3];
  wire [3:0] en;
  wire [3:0] pol;
  integer i;
  integer j;
  integer k;

  // Channel byte: low bits of each mode register belong to the odd channel
  assign mb[0] = mode1_q[7:0];
  assign mb[1] = mode1_q[15:8];
  assign mb[2] = mode2_q[7:0];
  assign mb[3] = mode2_q[15:8];
  assign en = {ctrl_q[12], ctrl_q[8], ctrl_q[4], ctrl_q[0]};
  assign pol = {ctrl_q[13], ctrl_q[9], ctrl_q[5], ctrl_q[1]};

  function [1:0] dir_of;
    input [7:0] b;
    dir_of = b[`TCMC_DIR_LSB+1:`TCMC_DIR_LSB];
  endfunction

  // Pick the source of a channel; the partner is the other member of its pair
  function src_pick;
    input [1:0] dir;
    input own;
    input partner;
    input trg;
    input int_sel;
    case (dir)
      `TCMC_DIR_OWN: src_pick = own;
      `TCMC_DIR_PAIR: src_pick = partner;
      `TCMC_DIR_TRG: src_pick = trg & (int_sel == `TCMC_SLAVE_TRIGGER_SELECT_INT); // R05
      default: src_pick = 1'b0;
    endcase
  endfunction

  // Base sampling clock tick counter, shared by all filters
  always @(posedge MCLK)
  begin
    if (RST)
      dts_cnt_q <= 4'h0;
    else
      dts_cnt_q <= dts_cnt_q + 4'h1;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      tcmc_filter u_flt
      (
        .MCLK(MCLK),
        .RST(RST),
        .cfg(mb[g][`TCMC_FLT_LSB+3:`TCMC_FLT_LSB]), // R09 R12 R13
        .dts_tick(1'b1),
        .dts_cnt(dts_cnt_q),
        .din(CH_IN[g] ^ pol[g]), // R17
        .dout_q(filt[g])
      );
      tcmc_divider u_div
      (
        .MCLK(MCLK),
        .RST(RST),
        .enable(en[g] & (dir_of(mb[g]) != `TCMC_DIR_OUT)), // R18
        .sel(mb[g][`TCMC_DIV_LSB+1:`TCMC_DIV_LSB]),
        .edge_in(edge_ev[g]),
        .capture(cap[g])
      );
    end
  endgenerate

  // Source selection per channel
  always @*
  begin
    chan_in[0] = src_pick(dir_of(mb[0]), filt[0], filt[1], TRIG_IN, SLAVE_TRIGGER_SELECT); // R02
    chan_in[1] = src_pick(dir_of(mb[1]), filt[1], filt[0], TRIG_IN, SLAVE_TRIGGER_SELECT); // R01
    chan_in[2] = src_pick(dir_of(mb[2]), filt[2], filt[3], TRIG_IN, SLAVE_TRIGGER_SELECT); // R03
    chan_in[3] = src_pick(dir_of(mb[3]), filt[3], filt[2], TRIG_IN, SLAVE_TRIGGER_SELECT); // R04
  end

  // Polarity already folded into the filtered level: a rise is the active edge
  always @*
  begin
    for (j = 0; j < 4; j = j + 1)
      edge_ev[j] = chan_in[j] & ~sel_lvl_q[j]; // R17
  end

  always @(posedge MCLK)
  begin
    if (RST)
    begin
      sel_lvl_q <= 4'h0;
      CAPTURE <= 4'h0;
      CH_TRIG <= 4'h0;
      capcnt_q <= 16'h0000;
    end
    else
    begin
      sel_lvl_q <= chan_in;
      CAPTURE <= cap;
      for (k = 0; k < 4; k = k + 1)
        CH_TRIG[k] <= filt[k] & en[k]; // R17 R18
      if (|cap)
        capcnt_q <= capcnt_q + 16'h0001;
    end
  end

  // Output-mode view; fields read as zero while the owning channel is an input
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      OUT_SWITCH_EN <= 4'h0;
      OUT_CONTROL <= 12'h000;
      OUT_BUFFER_EN <= 4'h0;
      OUT_IMMEDIATE_EN <= 4'h0;
      OUT_ENABLE <= 4'h0;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (dir_of(mb[i]) == `TCMC_DIR_OUT) // R16
        begin
          OUT_SWITCH_EN[i] <= mb[i][`TCMC_OSEN_BIT]; // R14 R15
          OUT_CONTROL[i*3 +: 3] <= mb[i][`TCMC_OCTRL_LSB+2:`TCMC_OCTRL_LSB]; // R14 R15
          OUT_BUFFER_EN[i] <= mb[i][`TCMC_OBEN_BIT]; // R14 R15
          OUT_IMMEDIATE_EN[i] <= mb[i][`TCMC_OIEN_BIT]; // R14 R15
          OUT_ENABLE[i] <= en[i]; // R18
        end
        else
        begin
          OUT_SWITCH_EN[i] <= 1'b0;
          OUT_CONTROL[i*3 +: 3] <= 3'h0;
          OUT_BUFFER_EN[i] <= 1'b0;
          OUT_IMMEDIATE_EN[i] <= 1'b0;
          OUT_ENABLE[i] <= 1'b0;
        end
      end
    end
  end

  // Direction bits only take a write while the channel is disabled
  function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] nw;
    input ch_en;
    merge_byte = ch_en ? {nw[7:2], old[1:0]} : nw; // R06
  endfunction

  always @(posedge MCLK)
  begin
    if (RST)
    begin
      mode1_q <= `TCMC_MODE_RST; // R19
      mode2_q <= `TCMC_MODE_RST; // R19
      ctrl_q <= `TCMC_CTRL_RST;
    end
    else if (WR)
    begin
      case (ADDR)
        `TCMC_OFS_MODE1:
          mode1_q <= {merge_byte(mode1_q[15:8], WDATA[15:8], en[1]), merge_byte(mode1_q[7:0], WDATA[7:0], en[0])};
        `TCMC_OFS_MODE2:
          mode2_q <= {merge_byte(mode2_q[15:8], WDATA[15:8], en[3]), merge_byte(mode2_q[7:0], WDATA[7:0], en[2])};
        `TCMC_OFS_CTRL:
          ctrl_q <= WDATA & `TCMC_CTRL_MASK;
        default:
          ctrl_q <= ctrl_q;
      endcase
    end
  end

  always @(posedge MCLK)
  begin
    if (RST)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        `TCMC_OFS_MODE1: RDATA <= mode1_q;
        `TCMC_OFS_MODE2: RDATA <= mode2_q;
        `TCMC_OFS_CTRL: RDATA <= ctrl_q;
        `TCMC_OFS_STAT: RDATA <= {8'h00, filt, chan_in};
        `TCMC_OFS_CAPCNT: RDATA <= capcnt_q;
        default: RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end
endmodule // tcmc_top

// >>> tcmc_top_monitor.sv
// Port checks for the channel mode configuration block
`timescale 1ns/1ps
`include "tcmc_map.vh"
module tcmc_monitor
(
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Register port
  input wire [`TCMC_ADDR_W-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  // Events and fields
  input wire [3:0] CAPTURE,
  input wire [3:0] CH_TRIG,
  input wire [3:0] OUT_SWITCH_EN,
  input wire [11:0] OUT_CONTROL,
  input wire [3:0] OUT_BUFFER_EN,
  input wire [3:0] OUT_IMMEDIATE_EN,
  input wire [3:0] OUT_ENABLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read");
  a_reset_clear: assert property ($fell(RST) |-> CAPTURE == 4'h0 && OUT_CONTROL == 12'h000)
    else $error("outputs not clear");
  a_mode_readback: assert property (WR && ADDR < 3'h2 ##1 RD && ADDR == $past(ADDR)
    |=> (RDATA & 16'hFCFC) == ($past(WDATA, 2) & 16'hFCFC))
    else $error("mode field lost");
  a_ch3_fields: assert property ($past(RD) && $past(ADDR) == 3'h1 && !$past(WR, 2) |->
    (RDATA[1:0] == 2'h0 ? OUT_CONTROL[8:6] == RDATA[6:4] && OUT_SWITCH_EN[2] == RDATA[7] : OUT_CONTROL[8:6] == 3'h0))
    else $error("ch3 output fields");
  a_ch4_fields: assert property ($past(RD) && $past(ADDR) == 3'h1 && !$past(WR, 2) |->
    (RDATA[9:8] == 2'h0 ? OUT_CONTROL[11:9] == RDATA[14:12] && OUT_SWITCH_EN[3] == RDATA[15] : !OUT_SWITCH_EN[3]))
    else $error("ch4 output fields");
  a_ctrl_mask: assert property ($past(RD) && $past(ADDR) == 3'h2 |-> (RDATA & 16'hCCCC) == 16'h0000)
    else $error("ctrl reserved bits");
  a_trig_gate: assert property ($past(RD) && $past(ADDR) == 3'h2 && !$past(WR, 2) && !$past(WR, 3) |->
    (CH_TRIG & ~{RDATA[12], RDATA[8], RDATA[4], RDATA[0]}) == 4'h0)
    else $error("trigger view while disabled");
  a_capture_single: assert property (CAPTURE[0] |=> !CAPTURE[0])
    else $error("capture pulse too long");
  a_ch34_flags: assert property ($past(RD) && $past(ADDR) == 3'h1 && !$past(WR, 2) |->
    (RDATA[1:0] == 2'h0 ? OUT_BUFFER_EN[2] == RDATA[3] && OUT_IMMEDIATE_EN[2] == RDATA[2] : !OUT_BUFFER_EN[2])
    && (RDATA[9:8] == 2'h0 ? OUT_BUFFER_EN[3] == RDATA[11] && OUT_IMMEDIATE_EN[3] == RDATA[10] : !OUT_BUFFER_EN[3]))
    else $error("ch3 ch4 output flags");
  a_out_enable: assert property ($past(RD) && $past(ADDR) == 3'h2 && !$past(WR, 2) && !$past(WR, 3) |->
    (OUT_ENABLE & ~{RDATA[12], RDATA[8], RDATA[4], RDATA[0]}) == 4'h0)
    else $error("output enable while disabled");
endmodule // tcmc_monitor
bind tcmc_top tcmc_monitor mon (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CAPTURE(CAPTURE), .CH_TRIG(CH_TRIG), .OUT_SWITCH_EN(OUT_SWITCH_EN), .OUT_CONTROL(OUT_CONTROL),
  .OUT_BUFFER_EN(OUT_BUFFER_EN), .OUT_IMMEDIATE_EN(OUT_IMMEDIATE_EN), .OUT_ENABLE(OUT_ENABLE));

// >>> tcmc_pins.sv
// Model of the capture pins and the internal trigger source
`timescale 1ns/1ps
module tcmc_pins
(
  // Clock
  input wire MCLK,
  // Pins
  output logic [3:0] CH_IN,
  output logic TRIG_IN
);
  logic [4:0] lvl_q = 5'h00;
  assign CH_IN = lvl_q[3:0];
  assign TRIG_IN = lvl_q[4];
  // Called at an edge; index 4 is the trigger
  task automatic drive(input int i, input logic v, input int n);
    lvl_q[i] <= v;
    repeat (n) @(posedge MCLK);
  endtask
  task automatic pulse(input int i, input int hi, input int lo);
    drive(i, 1'b1, hi);
    drive(i, 1'b0, lo);
  endtask
endmodule // tcmc_pins

// >>> timer_channel_mode_config_test.sv
// Self-checking bench of the channel mode configuration block
`timescale 1ns/1ps
module timer_channel_mode_config_test;
  logic MCLK = 1'b0;
  logic RST, WR, RD, sts, rd_seen = 1'b0;
  logic [2:0] ADDR;
  logic [15:0] WDATA, d, b;
  wire [15:0] RDATA;
  wire [3:0] CH_IN, CAPTURE, CH_TRIG;
  wire TRIG_IN;
  logic [15:0] cnt [4] = '{4{16'h0000}};
  logic [15:0] exp_q [$];
  logic [31:0] seed = 32'hB10C;
  int bad_count = 0;
  int n_compared = 0;
  initial forever #5 MCLK = ~MCLK;
  tcmc_top dut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CH_IN(CH_IN), .TRIG_IN(TRIG_IN), .SLAVE_TRIGGER_SELECT(sts), .CAPTURE(CAPTURE), .CH_TRIG(CH_TRIG),
    .OUT_SWITCH_EN(), .OUT_CONTROL(), .OUT_BUFFER_EN(), .OUT_IMMEDIATE_EN(), .OUT_ENABLE());
  tcmc_pins pins (.MCLK(MCLK), .CH_IN(CH_IN), .TRIG_IN(TRIG_IN));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus cycle; reads queue their expected data
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] v);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= v;
    if (r) exp_q.push_back(v);
    @(posedge MCLK);
  endtask
  task automatic cap(input int i, input logic [15:0] b0, input logic [15:0] e);
    repeat (12) @(posedge MCLK);
    chk(cnt[i] - b0, e);
  endtask
  always @(posedge MCLK)
  begin
    if (rd_seen) chk(RDATA, exp_q.pop_front());
    rd_seen <= RD;
    if (!RST) for (int k = 0; k < 4; k++) cnt[k] <= cnt[k] + CAPTURE[k];
  end
  initial
  begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 3'h0;
    WDATA = 16'h0000;
    sts = 1'b0;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    for (int a = 0; a < 6; a++) bus(0, 1, a[2:0], 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      d = rnd() & 16'hFCFC;
      bus(1, 0, 3'(k % 2), d);
      repeat (2) bus(0, 1, 3'(k % 2), d);
    end
    bus(1, 0, 2, 16'hFFFF);
    bus(0, 1, 2, 16'h3333);
    bus(1, 0, 2, 16'h0000);
    bus(1, 0, 0, 16'h0002);
    bus(1, 0, 2, 16'h0001);
    bus(1, 0, 0, 16'h0011);
    bus(0, 1, 0, 16'h0012);
    bus(1, 0, 2, 16'h0000);
    for (int i = 0; i < 4; i++)
      for (int c = 0; c < 5; c++)
      begin
        d = 16'(c > 2 ? 3 : c) << (8 * (i % 2));
        sts <= (c == 3);
        bus(1, 0, 3'(i / 2), d);
        repeat (2) bus(0, 1, 3'(i / 2), d);
        bus(1, 0, 2, 16'h0001 << (4 * i));
        bus(0, 0, 0, 16'h0000);
        b = cnt[i];
        repeat (3) pins.pulse(c == 1 ? i : c == 2 ? i ^ 1 : 4, 8, 8);
        cap(i, b, (c % 4 == 0) ? 16'h0000 : 16'h0003);
        bus(1, 0, 2, 16'h0000);
      end
    for (int v = 0; v < 4; v++)
    begin
      bus(1, 0, 0, 16'(v * 4 + 1));
      bus(1, 0, 2, 16'h0001);
      bus(0, 0, 0, 16'h0000);
      b = cnt[0];
      repeat ((2 << v) - 1) pins.pulse(0, 6, 6);
      cap(0, b, 16'h0001);
      bus(1, 0, 2, 16'h0000);
    end
    bus(1, 0, 0, 16'h0011);
    bus(1, 0, 2, 16'h0001);
    bus(0, 0, 0, 16'h0000);
    b = cnt[0];
    pins.pulse(0, 1, 10);
    cap(0, b, 16'h0000);
    pins.pulse(0, 3, 10);
    cap(0, b, 16'h0001);
    bus(1, 0, 0, 16'h0081);
    bus(0, 0, 0, 16'h0000);
    pins.pulse(0, 30, 80);
    cap(0, b, 16'h0001);
    pins.pulse(0, 70, 80);
    cap(0, b, 16'h0002);
    bus(1, 0, 2, 16'h0000);
    bus(1, 0, 0, 16'h0001);
    bus(0, 0, 0, 16'h0000);
    pins.drive(0, 1'b1, 4);
    bus(1, 0, 2, 16'h0003);
    bus(0, 0, 0, 16'h0000);
    b = cnt[0];
    pins.drive(0, 1'b1, 8);
    chk({15'h0000, CH_TRIG[0]}, 16'h0000);
    pins.drive(0, 1'b0, 8);
    chk({15'h0000, CH_TRIG[0]}, 16'h0001);
    pins.drive(0, 1'b1, 4);
    cap(0, b, 16'h0001);
    end_of_test();
  end
endmodule // timer_channel_mode_config_test
